//--- inc/lut_pkg.sv
package lut_pkg;

	// Table geometry: eleven points give ten slopes.
	localparam int LUT_POINTS = 11;
	localparam int LUT_LAST   = 10;
	localparam int LUT_IDX_W  = 4;
	localparam int LUT_DW     = 32;

	// Default Y span is 0 to 100 percent.
	localparam int LUT_PCT_MIN = 0;
	localparam int LUT_PCT_MAX = 100;

	// Time response figures, in milliseconds.
	localparam int LUT_DEF_STEP_MS     = 1000;
	localparam int LUT_MIN_INTERVAL_MS = 1;
	localparam int LUT_MAX_INTERVAL_MS = 86400000;

	// Clock rate and the millisecond tick derived from it.
	localparam int LUT_CLK_HZ     = 10000000;
	localparam int LUT_MS_PER_S   = 1000;
	localparam int LUT_CYC_PER_MS = LUT_CLK_HZ / LUT_MS_PER_S;

	// Response of the segment that ends at a point.
	typedef enum logic [1:0]
	{
		LUT_RAMP   = 2'h0,
		LUT_JUMP   = 2'h1,
		LUT_IGNORE = 2'h2
	} lut_resp_type;

	// One table point.
	typedef struct packed
	{
		lut_resp_type        resp;
		logic signed [31:0]  x;
		logic signed [31:0]  y;
	} lut_point_type;

	// Source selection and axis type.
	typedef struct packed
	{
		logic srcUsed;
		logic timeMode;
		logic srcDigital;
	} lut_cfg_type;

	// Input range of the selected source.
	typedef struct packed
	{
		logic signed [31:0] sourceFloor;
		logic signed [31:0] sourceCeiling;
	} lut_range_type;

endpackage

//--- design/lut_table.sv
`timescale 1ns/1ps
// Operation
// - Data mode compares the source value against the X points.
// - Point zero X defaults to zero, or to a negative source floor.
// - X points must be non-decreasing and, in data mode, inside the source range.
// - Ignored points are left out of the X ordering check.
// - Smallest and largest Y become the table output floor and ceiling.
// - Ignored Y values take no part in the output limits.
// - Tables come up disabled with no source selected.
// - Selecting a source defaults Y to 0..100 and X to source range, or to 1000 ms steps in time mode.
// - Default Y is evenly spaced over 0..100; data mode X points 1 to 10 span the source range evenly.
// - Points 1 to 10 default to ramp-to, linear interpolation.
// - Jump-to point outputs its own Y between previous and own X.
// - Ignore drops this and higher points; above previous X, previous Y.
// - Time mode X points are elapsed milliseconds, Y still output.
// - Time mode treats the source as on/off.
// - While on, follow the profile, then hold the final value.
// - Output is zero while off; each turn-on restarts at point zero.
// - Time intervals between X points run from 1 ms to 86,400,000 ms.
// - A digital source only ever measures zero or one.
// - Each table holds eleven response, X and Y entries.
// - Changing source or axis type reloads all points with defaults.
module lut_table
#(
	parameter int CYC_PER_MS = lut_pkg::LUT_CYC_PER_MS
)
(
	// Clock and reset.
	input  wire logic                    clock,
	input  wire logic                    sys_rst,
	// Source selection, range and value.
	input  wire lut_pkg::lut_cfg_type    cfg,
	input  wire lut_pkg::lut_range_type  srcRange,
	input  wire logic signed [31:0]      srcValue,
	// Point write port.
	input  wire logic                    wrEn,
	input  wire logic [3:0]              wrIdx,
	input  wire lut_pkg::lut_point_type  wrPoint,
	// Table output and limits.
	output logic signed [31:0]           tableOut,
	output logic signed [31:0]           tableOutFloor,
	output logic signed [31:0]           tableOutCeiling,
	// Status.
	output logic                         cfgError,
	output logic                         profileDone
);
	import lut_pkg::*;

	// A millisecond tick of zero cycles cannot be served.
	if (CYC_PER_MS < 1)
	begin : gBadTick
		$error("CYC_PER_MS must be at least one");
	end

	localparam logic [31:0] TICK_LAST = 32'(CYC_PER_MS - 1);

	lut_point_type       pts_ff [LUT_POINTS];
	lut_point_type       nxt_pts [LUT_POINTS];
	logic [1:0]          cfgSeen_ff;
	logic [1:0]          nxt_cfgSeen;
	logic [31:0]         tick_ff;
	logic [31:0]         nxt_tick;
	logic [31:0]         elapsed_ff;
	logic [31:0]         nxt_elapsed;
	logic signed [31:0]  out_ff;
	logic signed [31:0]  nxt_out;
	logic signed [31:0]  floor_ff;
	logic signed [31:0]  nxt_floor;
	logic signed [31:0]  ceil_ff;
	logic signed [31:0]  nxt_ceil;
	logic                err_ff;
	logic                nxt_err;
	logic                done_ff;
	logic                nxt_done;

	logic [3:0]          lastIdx;
	logic                ctrlOn;
	logic signed [31:0]  lookIn;
	logic signed [31:0]  lookOut;

	// Default value of one point for the present source and axis type.
	function automatic lut_point_type defPoint(input int idx,
		input lut_cfg_type c, input lut_range_type r);
		lut_point_type       p;
		logic signed [63:0]  span;
		logic signed [63:0]  xv;
		p      = '0;
		span   = 64'(r.sourceCeiling) - 64'(r.sourceFloor);
		p.resp = LUT_RAMP;
		p.y    = 32'(LUT_PCT_MIN + (LUT_PCT_MAX - LUT_PCT_MIN) * idx
			/ LUT_LAST);
		if (c.timeMode)
			xv = 64'(idx) * 64'(LUT_DEF_STEP_MS);
		else if (idx == 0)
			xv = (r.sourceFloor < 0) ? 64'(r.sourceFloor) : 64'sh0;
		else
			xv = 64'(r.sourceFloor) + span * 64'(idx - 1)
				/ 64'(LUT_LAST - 1);
		p.x = xv[31:0];
		return p;
	endfunction

	// Point storage: reset clears the points to zero, and any change of source or axis
	// type reloads the defaults, so writes made before the change are lost.
	always_comb
	begin
		nxt_cfgSeen = {cfg.srcUsed, cfg.timeMode};
		for (int i = 0; i < LUT_POINTS; i++)
			nxt_pts[i] = pts_ff[i];
		if (nxt_cfgSeen != cfgSeen_ff)
		begin
			for (int i = 0; i < LUT_POINTS; i++)
				nxt_pts[i] = defPoint(i, cfg, srcRange);
		end
		else if (wrEn && (wrIdx <= 4'(LUT_LAST)))
		begin
			nxt_pts[wrIdx] = wrPoint;
			if (wrIdx == 4'h0)
				nxt_pts[0].resp = LUT_RAMP;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			cfgSeen_ff <= 2'h0;
			for (int i = 0; i < LUT_POINTS; i++)
				pts_ff[i] <= '0;
		end
		else
		begin
			cfgSeen_ff <= nxt_cfgSeen;
			for (int i = 0; i < LUT_POINTS; i++)
				pts_ff[i] <= nxt_pts[i];
		end
	end

	// Last active point: the one before the first ignored point.
	always_comb
	begin
		logic hit;
		hit     = 1'b0;
		lastIdx = 4'(LUT_LAST);
		for (int i = 1; i < LUT_POINTS; i++)
		begin
			if (!hit && pts_ff[i].resp == LUT_IGNORE)
			begin
				hit     = 1'b1;
				lastIdx = 4'(i - 1);
			end
		end
	end

	// Control level: any non-zero value is on, and a digital source is
	// reduced to zero or one before use.
	always_comb
	begin
		ctrlOn = (srcValue != 32'sh0);
		if (cfg.timeMode)
			lookIn = signed'(elapsed_ff);
		else if (cfg.srcDigital)
			lookIn = ctrlOn ? 32'sh1 : 32'sh0;
		else
			lookIn = srcValue;
	end

	// Segment search and interpolation shared by both axis types.
	always_comb
	begin
		logic                found;
		logic signed [63:0]  dx;
		logic signed [63:0]  dy;
		logic signed [63:0]  num;
		found   = 1'b0;
		dx      = 64'sh0;
		dy      = 64'sh0;
		num     = 64'sh0;
		lookOut = pts_ff[lastIdx].y;
		if (lookIn < pts_ff[0].x)
		begin
			lookOut = pts_ff[0].y;
			found   = 1'b1;
		end
		for (int i = 1; i < LUT_POINTS; i++)
		begin
			if (!found && (4'(i) <= lastIdx) && (lookIn <= pts_ff[i].x))
			begin
				found = 1'b1;
				if (pts_ff[i].resp == LUT_JUMP)
					lookOut = pts_ff[i].y;
				else
				begin
					dx  = 64'(pts_ff[i].x) - 64'(pts_ff[i - 1].x);
					dy  = 64'(pts_ff[i].y) - 64'(pts_ff[i - 1].y);
					num = dy * (64'(lookIn) - 64'(pts_ff[i - 1].x));
					if (dx == 64'sh0)
						lookOut = pts_ff[i].y;
					else
						lookOut = 32'(64'(pts_ff[i - 1].y)
							+ num / dx);
				end
			end
		end
	end

	// Millisecond tick and elapsed time; both restart whenever the
	// control is off so every turn-on starts from point zero.
	always_comb
	begin
		logic tick;
		tick        = (tick_ff == TICK_LAST);
		nxt_tick    = tick ? 32'h0 : tick_ff + 32'h1;
		nxt_elapsed = elapsed_ff;
		nxt_done    = done_ff;
		// A reload cycle still sees the old points, so it counts as off;
		// otherwise stale X values could raise a false profileDone.
		if (!(cfg.srcUsed && cfg.timeMode && ctrlOn) ||
			(nxt_cfgSeen != cfgSeen_ff))
		begin
			nxt_tick    = 32'h0;
			nxt_elapsed = 32'h0;
			nxt_done    = 1'b0;
		end
		else if (signed'(elapsed_ff) >= pts_ff[lastIdx].x)
			nxt_done = 1'b1;
		else if (tick)
			nxt_elapsed = elapsed_ff + 32'h1;
	end

	// Output value: idle tables give zero, time mode gives zero while off.
	always_comb
	begin
		if (!cfg.srcUsed)
			nxt_out = 32'sh0;
		else if (cfg.timeMode && !ctrlOn)
			nxt_out = 32'sh0;
		else if (cfg.timeMode && done_ff)
			nxt_out = pts_ff[lastIdx].y;
		else
			nxt_out = lookOut;
	end

	// Output limits over active Y values, and the X consistency check.
	always_comb
	begin
		logic signed [63:0] gap;
		gap       = 64'sh0;
		nxt_floor = pts_ff[0].y;
		nxt_ceil  = pts_ff[0].y;
		nxt_err   = 1'b0;
		if (!cfg.timeMode && ((pts_ff[0].x < srcRange.sourceFloor) ||
			(pts_ff[0].x > srcRange.sourceCeiling)))
			nxt_err = 1'b1;
		for (int i = 1; i < LUT_POINTS; i++)
		begin
			if (4'(i) <= lastIdx)
			begin
				if (pts_ff[i].y < nxt_floor)
					nxt_floor = pts_ff[i].y;
				if (pts_ff[i].y > nxt_ceil)
					nxt_ceil = pts_ff[i].y;
				gap = 64'(pts_ff[i].x) - 64'(pts_ff[i - 1].x);
				if (gap < 64'sh0)
					nxt_err = 1'b1;
				if (!cfg.timeMode &&
					(pts_ff[i].x > srcRange.sourceCeiling))
					nxt_err = 1'b1;
				if (cfg.timeMode &&
					((gap < 64'(LUT_MIN_INTERVAL_MS)) ||
					(gap > 64'(LUT_MAX_INTERVAL_MS))))
					nxt_err = 1'b1;
			end
		end
		nxt_err = nxt_err && cfg.srcUsed;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			tick_ff    <= 32'h0;
			elapsed_ff <= 32'h0;
			done_ff    <= 1'b0;
			out_ff     <= 32'sh0;
			floor_ff   <= 32'sh0;
			ceil_ff    <= 32'sh0;
			err_ff     <= 1'b0;
		end
		else
		begin
			tick_ff    <= nxt_tick;
			elapsed_ff <= nxt_elapsed;
			done_ff    <= nxt_done;
			out_ff     <= nxt_out;
			floor_ff   <= nxt_floor;
			ceil_ff    <= nxt_ceil;
			err_ff     <= nxt_err;
		end
	end

	// All outputs come straight from flip-flops.
	assign tableOut        = out_ff;
	assign tableOutFloor   = floor_ff;
	assign tableOutCeiling = ceil_ff;
	assign cfgError        = err_ff;
	assign profileDone     = done_ff;

endmodule

//--- verification/lut_table_props.sv
`timescale 1ns/1ps
module lut_table_props
#(
	parameter int CYC_PER_MS = 4
)
(
	// Clock and reset.
	input wire logic                  clock,
	input wire logic                  sys_rst,
	// Watched inputs.
	input wire lut_pkg::lut_cfg_type  cfg,
	input wire logic signed [31:0]    srcValue,
	input wire logic                  wrEn,
	// Watched outputs.
	input wire logic signed [31:0]    tableOut,
	input wire logic signed [31:0]    tableOutFloor,
	input wire logic signed [31:0]    tableOutCeiling,
	input wire logic                  cfgError,
	input wire logic                  profileDone
);
	import lut_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// No write, reselection or reset may still be landing in the points
	// that the next output is computed from; a reload lags one edge.
	sequence quiet;
		!wrEn && !$past(wrEn) && $stable(cfg) &&
			($past(cfg) == $past(cfg, 2)) &&
			!$past(sys_rst) && !$past(sys_rst, 2);
	endsequence
	// Time mode with the control input off.
	sequence offTime;
		cfg.srcUsed && cfg.timeMode && srcValue == 0;
	endsequence
	unused_zero_a: assert property (
		!cfg.srcUsed [*2] |=> tableOut == 0)
		else $error("output not zero without a source");
	off_zero_a: assert property (
		offTime [*2] |=> tableOut == 0 && !profileDone)
		else $error("time output not zero while off");
	done_hold_a: assert property (
		profileDone && srcValue != 0 ##0 quiet |=> $stable(tableOut))
		else $error("finished profile did not hold");
	limit_order_a: assert property (
		tableOutFloor <= tableOutCeiling)
		else $error("output floor above ceiling");
	data_steady_a: assert property (
		!cfg.timeMode && $stable(srcValue) ##0 quiet
			|=> $stable(tableOut))
		else $error("data output moved with steady input");
	limit_steady_a: assert property (
		quiet |=> $stable(tableOutFloor) && $stable(tableOutCeiling))
		else $error("limits moved without a write");
	cfg_clean_a: assert property (
		!cfg.srcUsed [*2] |=> !cfgError)
		else $error("error flagged without a source");
	reset_clear_a: assert property (
		disable iff (1'b0) sys_rst |=> tableOut == 0 &&
			tableOutCeiling == 0 && !cfgError && !profileDone)
		else $error("outputs not cleared by reset");
endmodule

//--- verification/lut_source_model.sv
`timescale 1ns/1ps
module lut_source_model
(
	// Clock.
	input wire logic                clock,
	// Requested level and kind.
	input wire logic                digital,
	input wire logic signed [31:0]  level,
	// Source value.
	output logic signed [31:0]      srcValue
);
	// A digital source only reports zero or one, one edge late.
	always_ff @(posedge clock)
	begin
		srcValue <= digital ? {31'h0, level != 0} : level;
	end
endmodule

//--- verification/lookup_table_response_bench.sv
`timescale 1ns/1ps
module lookup_table_response_bench;
	import lut_pkg::*;
	logic clock, sys_rst, wrEn, dig, cfgError, profileDone;
	logic [3:0] wrIdx;
	logic signed [31:0] level, srcValue, tableOut;
	logic signed [31:0] tableOutFloor, tableOutCeiling;
	lut_cfg_type cfg;
	lut_range_type srcRange;
	lut_point_type wrPoint;
	int px[11], py[11], pr[11];
	int failures, samples_checked, n;
	lut_table #(.CYC_PER_MS(4)) i_lut_table (.clock(clock), .sys_rst(sys_rst),
		.cfg(cfg), .srcRange(srcRange), .srcValue(srcValue), .wrEn(wrEn),
		.wrIdx(wrIdx), .wrPoint(wrPoint), .tableOut(tableOut),
		.tableOutFloor(tableOutFloor), .tableOutCeiling(tableOutCeiling),
		.cfgError(cfgError), .profileDone(profileDone));
	lut_source_model i_lut_source_model (.clock(clock), .digital(dig),
		.level(level), .srcValue(srcValue));
	// Clock at 100 ns.
	initial
	begin
		clock = 0;
		forever #50 clock = ~clock;
	end
	task automatic chk(input logic signed [31:0] seen,
		input logic signed [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Reference defaults, reloaded on every source or type change.
	function automatic void defs(input bit tm);
		for (int i = 0; i < 11; i++)
		begin
			pr[i] = 0;
			py[i] = 100 * i / 10;
			if (tm)
				px[i] = i * LUT_DEF_STEP_MS;
			else if (i == 0)
				px[i] = srcRange.sourceFloor < 0 ? srcRange.sourceFloor : 0;
			else
				px[i] = srcRange.sourceFloor + (srcRange.sourceCeiling
					- srcRange.sourceFloor) * (i - 1) / 9;
		end
	endfunction
	// Reference lookup; ignoring ends the table.
	function automatic int ref_out(input int v);
		ref_out = py[0];
		if (v < px[0])
			return py[0];
		for (int i = 1; i < 11 && pr[i] != 2; i++)
		begin
			if (v <= px[i])
				return pr[i] == 1 || px[i] == px[i-1] ? py[i]
					: py[i-1] + (py[i] - py[i-1]) * (v - px[i-1])
					/ (px[i] - px[i-1]);
			ref_out = py[i];
		end
	endfunction
	task automatic wr(input int i, input int r, input int x, input int y);
		@(negedge clock);
		wrEn = 1;
		wrIdx = i[3:0];
		wrPoint = '{lut_resp_type'(r[1:0]), x, y};
		pr[i] = r;
		px[i] = x;
		py[i] = y;
		@(negedge clock);
		wrEn = 0;
		repeat (2) @(negedge clock);
	endtask
	// Random data inputs, analogue or digital, against the reference.
	task automatic sweep;
		repeat (40)
		begin
			@(negedge clock);
			level = $signed($urandom_range(110)) - 50;
			dig = $urandom_range(1);
			cfg.srcDigital = dig;
			repeat (3) @(negedge clock);
			chk(tableOut, ref_out(dig ? int'(level != 0) : level));
		end
	endtask
	initial
	begin
		{sys_rst, wrEn, dig, wrIdx} = 7'h40;
		{cfg, level, wrPoint} = '0;
		srcRange = '{-40, 50};
		void'($urandom(34));
		repeat (16) @(negedge clock);
		sys_rst = 0;
		repeat (2) @(negedge clock);
		chk(tableOut, 0);
		cfg = '{1'b1, 1'b0, 1'b0};
		defs(0);
		repeat (3) @(negedge clock);
		chk(tableOutCeiling, 100);
		chk(tableOutFloor, 0);
		chk(cfgError, 0);
		sweep();
		$display("test defaults done");
		wr(3, 1, -15, 70);
		wr(8, 0, 900, 80);
		chk(cfgError, 1);
		wr(6, 2, 0, 500);
		chk(cfgError, 0);
		chk(tableOutCeiling, 70);
		wr(4, 0, -10, -20);
		chk(tableOutFloor, -20);
		sweep();
		$display("test jump and ignore done");
		cfg = '{1'b1, 1'b1, 1'b0};
		dig = 0;
		level = 0;
		defs(1);
		// Edits run from the top index down; the shrinking X values may
		// flag a passing ordering error, which must be gone at the end.
		for (int i = 10; i > 0; i--)
			wr(i, 0, 2 * i, py[i]);
		chk(cfgError, 0);
		repeat (2)
		begin
			chk(tableOut, 0);
			level = $urandom_range(1000, 1);
			repeat (3) @(negedge clock);
			chk(profileDone, 0);
			for (n = 0; n < 200 && profileDone !== 1; n++)
				@(negedge clock);
			if (profileDone !== 1)
			begin
				failures++;
				close_out();
			end
			chk(tableOut, 100);
			level = 0;
			repeat (3) @(negedge clock);
		end
		wr(10, 0, 18, 100);
		chk(cfgError, 1);
		$display("test time profile done");
		close_out();
	end
endmodule
bind lut_table lut_table_props #(.CYC_PER_MS(CYC_PER_MS)) i_lut_table_props (
	.clock(clock), .sys_rst(sys_rst), .cfg(cfg), .srcValue(srcValue),
	.wrEn(wrEn), .tableOut(tableOut), .tableOutFloor(tableOutFloor),
	.tableOutCeiling(tableOutCeiling), .cfgError(cfgError),
	.profileDone(profileDone));
